// ==== verilog/nvm_access_ctrl.sv ====
// data eeprom access control: registers, indirect window, sequencer, interrupt flag
`timescale 1ns/1ps
// What this block does
// - read go with read permit already set starts a read at address
// - read go ignored when read permit is low
// - read end clears read go and loads fetched byte into data register
// - data register holds last byte until another read or write
// - write go ignored when write permit is low
// - write length set by free running timer, not fixed clock count
// - write end clears write go; byte was already stored at write start
// - write permit resets to zero
// - pointer high bytes reset to zero, control register unreachable
// - every write end sets interrupt request flag
// - flag with both enables and stack not full requests the vector
// - servicing the interrupt clears the flag
// - control register at sector 1 location 40h, indirect only
// - control bits: write permit 3, write go 2, read permit 1, read go 0
// - array holds 256 bytes on eight bit address
module nvm_access_ctrl
  import nvm_access_pkg::*;
#(
  parameter int READ_CYCLES = nvm_access_pkg::READ_CYCLES_DEFAULT,
  parameter int WRITE_TICKS = nvm_access_pkg::WRITE_TICKS_DEFAULT,
  parameter int TICK_DIV    = nvm_access_pkg::TIMER_DIV
) (
  // clock and reset
  input  wire logic                          mclk,
  input  wire logic                          reset,
  // software register port
  input  nvm_access_pkg::reg_req_t           req,
  output logic [nvm_access_pkg::DATA_W-1:0]  rdata,
  // interrupt handshake with the core
  input  wire logic                          stack_full,
  input  wire logic                          irq_ack,
  output logic                               irq_vector_req
);
  import nvm_access_pkg::*;

  localparam int CW = $clog2(READ_CYCLES + 1);
  localparam logic [CW-1:0] READ_LOAD = CW'(READ_CYCLES - 1);

  // true when a pointer pair names the control register
  function automatic logic points_to_ctrl(input logic [7:0] hi, input logic [7:0] lo);
    points_to_ctrl = (hi == CTRL_SECTOR) && (lo == CTRL_LOC);
  endfunction

  nvm_state_t          state_reg;
  nvm_state_t          state_next;
  logic [CTRL_W-1:0]   nvm_ctrl_reg;
  logic [CTRL_W-1:0]   nvm_ctrl_next;
  logic [CW-1:0]       rd_cnt_reg;
  logic [CW-1:0]       rd_cnt_next;
  logic [7:0]          nvm_addr_reg;
  logic [7:0]          nvm_addr_next;
  logic [7:0]          nvm_data_reg;
  logic [7:0]          nvm_data_next;
  logic [7:0]          pointer1_low_reg;
  logic [7:0]          pointer1_low_next;
  logic [7:0]          pointer1_high_byte_reg;
  logic [7:0]          pointer1_high_byte_next;
  logic [7:0]          pointer2_low_reg;
  logic [7:0]          pointer2_low_next;
  logic [7:0]          pointer2_high_byte_reg;
  logic [7:0]          pointer2_high_byte_next;
  logic                global_irq_enable_reg;
  logic                global_irq_enable_next;
  logic                nvm_irq_enable_reg;
  logic                nvm_irq_enable_next;
  logic                nvm_irq_flag_reg;
  logic                nvm_irq_flag_next;
  logic [7:0]          rdata_next;
  logic                ctrl_sel;
  logic                ctrl_wr;
  logic                start_read;
  logic                start_write;
  logic                read_end;
  logic                write_done;
  logic                timer_done;
  logic [7:0]          array_rdata;
  array_req_t          array_req;
  logic                read_permit;
  logic                write_permit;

  assign read_permit  = nvm_ctrl_reg[READ_PERMIT_BIT];
  assign write_permit = nvm_ctrl_reg[WRITE_PERMIT_BIT];

  // control register reached only through an indirect port
  // indirect decode
  always_comb
  begin
    ctrl_sel = ((req.addr == OFS_IND1) && points_to_ctrl(pointer1_high_byte_reg, pointer1_low_reg))
            || ((req.addr == OFS_IND2) && points_to_ctrl(pointer2_high_byte_reg, pointer2_low_reg));
    ctrl_wr  = req.wr && ctrl_sel;
  end

  // sequencer and control register next state
  always_comb
  begin
    state_next    = state_reg;
    nvm_ctrl_next = nvm_ctrl_reg;
    rd_cnt_next   = rd_cnt_reg;
    start_read    = 1'b0;
    start_write   = 1'b0;
    read_end      = 1'b0;
    write_done    = 1'b0;
    // permit bits are always writable; go bits only through acceptance
    if (ctrl_wr)
    begin
      nvm_ctrl_next[READ_PERMIT_BIT]  = req.wdata[READ_PERMIT_BIT];
      nvm_ctrl_next[WRITE_PERMIT_BIT] = req.wdata[WRITE_PERMIT_BIT];
    end
    case (state_reg)
      ST_IDLE:
      begin
        if (ctrl_wr && req.wdata[READ_GO_BIT] && read_permit)
        begin
          start_read                 = 1'b1;
          nvm_ctrl_next[READ_GO_BIT] = 1'b1;
          rd_cnt_next                = READ_LOAD;
          state_next                 = ST_READ;
        end
        else if (ctrl_wr && req.wdata[WRITE_GO_BIT] && write_permit)
        begin
          start_write                 = 1'b1;
          nvm_ctrl_next[WRITE_GO_BIT] = 1'b1;
          state_next                  = ST_WRITE;
        end
      end
      ST_READ:
      begin
        nvm_ctrl_next[READ_GO_BIT] = 1'b1;
        rd_cnt_next                = rd_cnt_reg - CW'(1);
        if (rd_cnt_reg == '0)
        begin
          read_end                   = 1'b1;
          nvm_ctrl_next[READ_GO_BIT] = 1'b0;
          rd_cnt_next                = '0;
          state_next                 = ST_IDLE;
        end
      end
      ST_WRITE:
      begin
        nvm_ctrl_next[WRITE_GO_BIT] = 1'b1;
        if (timer_done)
        begin
          write_done                  = 1'b1;
          nvm_ctrl_next[WRITE_GO_BIT] = 1'b0;
          state_next                  = ST_IDLE;
        end
      end
      default:
      begin
        state_next    = ST_IDLE;
        nvm_ctrl_next = CTRL_RESET;
      end
    endcase
  end

  // direct registers: address, data and memory pointers
  always_comb
  begin
    nvm_addr_next           = nvm_addr_reg;
    nvm_data_next           = nvm_data_reg;
    pointer1_low_next       = pointer1_low_reg;
    pointer1_high_byte_next = pointer1_high_byte_reg;
    pointer2_low_next       = pointer2_low_reg;
    pointer2_high_byte_next = pointer2_high_byte_reg;
    if (req.wr)
    begin
      case (req.addr)
        OFS_NVM_ADDR: nvm_addr_next = req.wdata;
        OFS_NVM_DATA: nvm_data_next = req.wdata;
        OFS_PTR1_LO:  pointer1_low_next = req.wdata;
        OFS_PTR1_HI:  pointer1_high_byte_next = req.wdata;
        OFS_PTR2_LO:  pointer2_low_next = req.wdata;
        OFS_PTR2_HI:  pointer2_high_byte_next = req.wdata;
        default:      nvm_addr_next = nvm_addr_reg;
      endcase
    end
    // fetched byte wins over a software store
    if (read_end)
    begin
      nvm_data_next = array_rdata;
    end
  end

  // interrupt enables and sticky request flag
  always_comb
  begin
    global_irq_enable_next = global_irq_enable_reg;
    nvm_irq_enable_next    = nvm_irq_enable_reg;
    nvm_irq_flag_next      = nvm_irq_flag_reg;
    if (req.wr && (req.addr == OFS_IRQ_CTRL))
    begin
      global_irq_enable_next = req.wdata[IRQ_GLOBAL_BIT];
      nvm_irq_enable_next    = req.wdata[IRQ_NVM_EN_BIT];
      nvm_irq_flag_next      = req.wdata[IRQ_FLAG_BIT];
    end
    if (irq_ack)
    begin
      nvm_irq_flag_next = 1'b0;
    end
    // write end sets flag; set beats any clear
    if (write_done)
    begin
      nvm_irq_flag_next = 1'b1;
    end
  end

  assign irq_vector_req = nvm_irq_flag_reg && nvm_irq_enable_reg && global_irq_enable_reg && !stack_full;

  // read data mux, answered one cycle after the strobe
  always_comb
  begin
    rdata_next = BYTE_RESET;
    if (req.rd)
    begin
      case (req.addr)
        OFS_NVM_ADDR: rdata_next = nvm_addr_reg;
        OFS_NVM_DATA: rdata_next = nvm_data_reg;
        OFS_PTR1_LO:  rdata_next = pointer1_low_reg;
        OFS_PTR1_HI:  rdata_next = pointer1_high_byte_reg;
        OFS_PTR2_LO:  rdata_next = pointer2_low_reg;
        OFS_PTR2_HI:  rdata_next = pointer2_high_byte_reg;
        OFS_IRQ_CTRL: rdata_next = {5'h00, nvm_irq_flag_reg, nvm_irq_enable_reg, global_irq_enable_reg};
        default:      rdata_next = ctrl_sel ? {4'h0, nvm_ctrl_reg} : BYTE_RESET;
      endcase
    end
  end

  // all control state
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state_reg              <= ST_IDLE;
      nvm_ctrl_reg           <= CTRL_RESET;
      rd_cnt_reg             <= '0;
      nvm_addr_reg           <= BYTE_RESET;
      nvm_data_reg           <= BYTE_RESET;
      pointer1_low_reg       <= BYTE_RESET;
      pointer1_high_byte_reg <= BYTE_RESET;
      pointer2_low_reg       <= BYTE_RESET;
      pointer2_high_byte_reg <= BYTE_RESET;
      global_irq_enable_reg  <= 1'b0;
      nvm_irq_enable_reg     <= 1'b0;
      nvm_irq_flag_reg       <= 1'b0;
      rdata                  <= BYTE_RESET;
    end
    else
    begin
      state_reg              <= state_next;
      nvm_ctrl_reg           <= nvm_ctrl_next;
      rd_cnt_reg             <= rd_cnt_next;
      nvm_addr_reg           <= nvm_addr_next;
      nvm_data_reg           <= nvm_data_next;
      pointer1_low_reg       <= pointer1_low_next;
      pointer1_high_byte_reg <= pointer1_high_byte_next;
      pointer2_low_reg       <= pointer2_low_next;
      pointer2_high_byte_reg <= pointer2_high_byte_next;
      global_irq_enable_reg  <= global_irq_enable_next;
      nvm_irq_enable_reg     <= nvm_irq_enable_next;
      nvm_irq_flag_reg       <= nvm_irq_flag_next;
      rdata                  <= rdata_next;
    end
  end

  // array port; byte is committed at write start
  always_comb
  begin
    array_req.we    = start_write;
    array_req.addr  = nvm_addr_reg;
    array_req.wdata = nvm_data_reg;
  end

  nvm_byte_array #(
    .DEPTH (NVM_DEPTH)
  ) u_array (
    .mclk  (mclk),
    .req   (array_req),
    .rdata (array_rdata)
  );

  nvm_write_timer #(
    .TICK_DIV    (TICK_DIV),
    .WRITE_TICKS (WRITE_TICKS)
  ) u_timer (
    .mclk  (mclk),
    .reset (reset),
    .start (start_write),
    .done  (timer_done)
  );

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  AST_READ_START: assert property (
    (state_reg == ST_IDLE && ctrl_wr && req.wdata[READ_GO_BIT] && read_permit)
    |=> (state_reg == ST_READ) && nvm_ctrl_reg[READ_GO_BIT])
    else $error("read go with permit did not start a read");

  AST_READ_REFUSED: assert property (
    (state_reg == ST_IDLE && ctrl_wr && req.wdata[READ_GO_BIT] && !read_permit)
    |=> !nvm_ctrl_reg[READ_GO_BIT] && (state_reg != ST_READ))
    else $error("read started without permit");

  AST_READ_END: assert property (
    (state_reg == ST_READ && rd_cnt_reg == '0)
    |=> !nvm_ctrl_reg[READ_GO_BIT] && (nvm_data_reg == $past(array_rdata)))
    else $error("read end did not clear go or load data");

  AST_READ_LENGTH: assert property (
    (state_reg == ST_IDLE && start_read)
    |=> nvm_ctrl_reg[READ_GO_BIT] [*4] ##1 !nvm_ctrl_reg[READ_GO_BIT])
    else $error("read go not held for the read length");

  AST_DATA_HOLD: assert property (
    (!read_end && !(req.wr && req.addr == OFS_NVM_DATA))
    |=> $stable(nvm_data_reg))
    else $error("data register changed without an operation");

  AST_WRITE_REFUSED: assert property (
    (state_reg == ST_IDLE && ctrl_wr && req.wdata[WRITE_GO_BIT] && !write_permit && !req.wdata[READ_GO_BIT])
    |=> !nvm_ctrl_reg[WRITE_GO_BIT] && (state_reg == ST_IDLE))
    else $error("write started without permit");

  AST_WRITE_END: assert property (
    (state_reg == ST_WRITE && timer_done)
    |=> !nvm_ctrl_reg[WRITE_GO_BIT] && (state_reg == ST_IDLE))
    else $error("write end did not clear write go");

  AST_FLAG_SET: assert property (
    write_done |=> nvm_irq_flag_reg)
    else $error("write end did not raise the flag");

  AST_FLAG_CLEAR: assert property (
    (irq_ack && !write_done && !(req.wr && req.addr == OFS_IRQ_CTRL)) |=> !nvm_irq_flag_reg)
    else $error("service did not clear the flag");

  AST_BUSY_IGNORE: assert property (
    (state_reg == ST_WRITE && !timer_done) |=> (state_reg == ST_WRITE) && !nvm_ctrl_reg[READ_GO_BIT])
    else $error("busy write disturbed by a go set");

  AST_POINTER_RESET: assert property (
    $past(reset) |-> (pointer1_high_byte_reg == 8'h00) && (pointer2_high_byte_reg == 8'h00)
                     && !write_permit)
    else $error("pointer high byte or write permit not cleared by reset");
endmodule

// ==== verilog/nvm_access_pkg.sv ====
// shared constants, types and register map for the data eeprom access block
package nvm_access_pkg;

  // data widths and array size
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 8;
  localparam int NVM_DEPTH = 256;

  // direct register offsets on the software port
  localparam logic [7:0] OFS_IND1     = 8'h00;
  localparam logic [7:0] OFS_PTR1_LO  = 8'h01;
  localparam logic [7:0] OFS_PTR1_HI  = 8'h02;
  localparam logic [7:0] OFS_IND2     = 8'h03;
  localparam logic [7:0] OFS_PTR2_LO  = 8'h04;
  localparam logic [7:0] OFS_PTR2_HI  = 8'h05;
  localparam logic [7:0] OFS_IRQ_CTRL = 8'h0E;
  localparam logic [7:0] OFS_NVM_ADDR = 8'h10;
  localparam logic [7:0] OFS_NVM_DATA = 8'h11;

  // control register home: sector 1, location 40h
  localparam logic [7:0] CTRL_SECTOR = 8'h01;
  localparam logic [7:0] CTRL_LOC    = 8'h40;

  // control register fields
  localparam int CTRL_W            = 4;
  localparam int WRITE_PERMIT_BIT  = 3;
  localparam int WRITE_GO_BIT      = 2;
  localparam int READ_PERMIT_BIT   = 1;
  localparam int READ_GO_BIT       = 0;

  // interrupt control register fields
  localparam int IRQ_GLOBAL_BIT = 0;
  localparam int IRQ_NVM_EN_BIT = 1;
  localparam int IRQ_FLAG_BIT   = 2;

  // reset values
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // timing
  localparam int CLK_PERIOD_NS       = 50;
  localparam int TIMER_PERIOD_NS     = 1000;
  localparam int TIMER_DIV           = (TIMER_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_TICKS_DEFAULT = 2000;
  localparam int READ_CYCLES_DEFAULT = 4;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b100
  } nvm_state_t;

  // software register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  // array access request
  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } array_req_t;

endpackage

// ==== verilog/nvm_write_timer.sv ====
// write cycle timer clocked from a free running prescaler
`timescale 1ns/1ps
module nvm_write_timer #(
  parameter int TICK_DIV    = 20,
  parameter int WRITE_TICKS = 2000
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic reset,
  // control
  input  wire logic start,
  output logic      done
);
  localparam int DW = $clog2(TICK_DIV + 1);
  localparam int TW = $clog2(WRITE_TICKS + 1);
  localparam logic [DW-1:0] DIV_LAST  = DW'(TICK_DIV - 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(WRITE_TICKS);

  logic [DW-1:0] div_reg;
  logic [DW-1:0] div_next;
  logic [TW-1:0] tick_reg;
  logic [TW-1:0] tick_next;
  logic          run_reg;
  logic          run_next;
  logic          tick;

  // prescaler never stops, so the write length drifts with its phase
  always_comb
  begin
    tick      = (div_reg == DIV_LAST);
    div_next  = tick ? '0 : div_reg + DW'(1);
    run_next  = run_reg;
    tick_next = tick_reg;
    done      = 1'b0;
    if (start)
    begin
      run_next  = 1'b1;
      tick_next = '0;
    end
    else if (run_reg && tick)
    begin
      tick_next = tick_reg + TW'(1);
      if (tick_reg == TICK_LAST - TW'(1))
      begin
        run_next = 1'b0;
        done     = 1'b1;
      end
    end
  end

  // state registers
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      div_reg  <= '0;
      tick_reg <= '0;
      run_reg  <= 1'b0;
    end
    else
    begin
      div_reg  <= div_next;
      tick_reg <= tick_next;
      run_reg  <= run_next;
    end
  end
endmodule

// ==== verilog/nvm_byte_array.sv ====
// byte wide nonvolatile array model with registered read
`timescale 1ns/1ps
module nvm_byte_array
  import nvm_access_pkg::*;
#(
  parameter int DEPTH = 256
) (
  // clock
  input  wire logic                     mclk,
  // access
  input  nvm_access_pkg::array_req_t    req,
  output logic [nvm_access_pkg::DATA_W-1:0] rdata
);
  logic [DATA_W-1:0] mem [DEPTH];
  logic [DATA_W-1:0] rdata_next;

  // read is free running; caller samples after its own latency
  always_comb
  begin
    rdata_next = mem[req.addr];
  end

  // contents are retained storage, so no reset
  always_ff @(posedge mclk)
  begin
    if (req.we)
    begin
      mem[req.addr] <= req.wdata;
    end
    rdata <= rdata_next;
  end
endmodule

// ==== bench/nvm_access_ctrl_tb.sv ====
// self-checking bench for the data eeprom access control block
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module nvm_access_ctrl_tb;
  import nvm_access_pkg::*;

  // shortened counts so a write lasts a handful of cycles
  localparam int WT    = 3;
  localparam int TD    = 2;
  localparam int RC    = 4;
  localparam int LO    = (WT - 1) * TD + 2;
  localparam int HI    = WT * TD + 2;
  localparam int LIMIT = 5000;

  // design ports
  logic              mclk;
  logic              reset;
  reg_req_t          req;
  logic [DATA_W-1:0] rdata;
  logic              stack_full;
  logic              irq_ack;
  logic              irq_vector_req;

  // bench bookkeeping
  int                n_mismatch;
  int                tests_run;
  int                cyc;
  time               t_go;
  time               t_irq;
  logic [7:0]        v;

  nvm_access_ctrl #(
    .READ_CYCLES (RC),
    .WRITE_TICKS (WT),
    .TICK_DIV    (TD)
  ) dut (
    .mclk           (mclk),
    .reset          (reset),
    .req            (req),
    .rdata          (rdata),
    .stack_full     (stack_full),
    .irq_ack        (irq_ack),
    .irq_vector_req (irq_vector_req)
  );

  // 20 mhz clock
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // hang guard, far above the expected run length
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      n_mismatch++;
      $display("[ERR] %0t timeout", $time);
      end_sim();
    end
  end

  // first edge that sees the vector request, for write length
  always @(posedge mclk)
  begin
    if (irq_vector_req === 1'b1 && t_irq == 0)
      t_irq = $time;
  end

  // counts, verdict and stop
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // drive one request; it is taken at the following edge
  task automatic put(input reg_req_t r);
    @(posedge mclk);
    req <= r;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    put('{a, d, 1'b1, 1'b0});
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    put('{a, 8'h00, 1'b0, 1'b1});
    @(posedge mclk);
    req <= '0;
    #1;
    q = rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    rd(a, v);
    `CHK(v, e)
  endtask

  // poll the control register until the masked go bit drops
  task automatic poll(input logic [7:0] mask);
    int k;
    for (k = 0; k < 50; k++)
    begin
      rd(OFS_IND1, v);
      if ((v & mask) === 8'h00)
        break;
    end
    `CHK(v & mask, 8'h00)
  endtask

  // permit then go in consecutive cycles
  task automatic nvm_write(input logic [7:0] a, input logic [7:0] d);
    wr(OFS_NVM_ADDR, a);
    wr(OFS_NVM_DATA, d);
    wr(OFS_IND1, 8'h08);
    wr(OFS_IND1, 8'h0C);
    poll(8'h04);
  endtask

  // data register is scribbled first so only a real fetch can pass
  task automatic nvm_read(input logic [7:0] a, input logic [7:0] e);
    wr(OFS_NVM_ADDR, a);
    wr(OFS_NVM_DATA, 8'h00);
    wr(OFS_IND1, 8'h02);
    wr(OFS_IND1, 8'h03);
    rd_chk(OFS_IND1, 8'h03);
    poll(8'h01);
    rd_chk(OFS_NVM_DATA, e);
  endtask

  // main sequence
  initial
  begin
    req        = '0;
    reset      = 1'b1;
    stack_full = 1'b0;
    irq_ack    = 1'b0;
    n_mismatch = 0;
    tests_run  = 0;
    cyc        = 0;
    t_go       = 0;
    t_irq      = 0;
    v          = 8'h00;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    // reset state, pointer guard and unmapped space
    rd_chk(OFS_PTR1_HI, 8'h00);
    rd_chk(OFS_PTR2_HI, 8'h00);
    rd_chk(OFS_NVM_DATA, 8'h00);
    rd_chk(8'h20, 8'h00);
    wr(OFS_PTR1_LO, CTRL_LOC);
    wr(OFS_IND1, 8'h0A);
    wr(OFS_PTR1_HI, CTRL_SECTOR);
    rd_chk(OFS_IND1, 8'h00);
    // go bits refused without a stored permit
    wr(OFS_IND1, 8'h01);
    rd_chk(OFS_IND1, 8'h00);
    wr(OFS_IND1, 8'h04);
    rd_chk(OFS_IND1, 8'h00);
    wr(OFS_IND1, 8'h03);
    rd_chk(OFS_IND1, 8'h02);
    wr(OFS_IND1, 8'hF2);
    rd_chk(OFS_IND1, 8'h02);
    wr(OFS_PTR2_LO, CTRL_LOC);
    wr(OFS_PTR2_HI, CTRL_SECTOR);
    rd_chk(OFS_IND2, 8'h02);
    // timed write, global enable only after the start
    // global enable held off
    wr(OFS_IRQ_CTRL, 8'h02);
    wr(OFS_NVM_ADDR, 8'h5A);
    wr(OFS_NVM_DATA, 8'hA5);
    wr(OFS_IND1, 8'h08);
    wr(OFS_IND1, 8'h0C);
    wr(OFS_IRQ_CTRL, 8'h03);
    t_go  = $time;
    t_irq = 0;
    wr(OFS_IND1, 8'h0A);
    wr(OFS_IND1, 8'h0B);
    rd_chk(OFS_IND1, 8'h0E);
    repeat (20) @(posedge mclk);
    `CHK(((t_irq - t_go) / 50) inside {[LO:HI]}, 1'b1)
    rd_chk(OFS_IND1, 8'h0A);
    rd_chk(OFS_IRQ_CTRL, 8'h07);
    `CHK(irq_vector_req, 1'b1)
    // stack full, global enable and flag qualifiers of the vector request
    @(posedge mclk);
    stack_full <= 1'b1;
    #10;
    `CHK(irq_vector_req, 1'b0)
    @(posedge mclk);
    stack_full <= 1'b0;
    wr(OFS_IRQ_CTRL, 8'h06);
    rd_chk(OFS_IRQ_CTRL, 8'h06);
    `CHK(irq_vector_req, 1'b0)
    wr(OFS_IRQ_CTRL, 8'h07);
    rd_chk(OFS_IRQ_CTRL, 8'h07);
    `CHK(irq_vector_req, 1'b1)
    @(posedge mclk);
    irq_ack <= 1'b1;
    @(posedge mclk);
    irq_ack <= 1'b0;
    rd_chk(OFS_IRQ_CTRL, 8'h03);
    `CHK(irq_vector_req, 1'b0)
    // read back and data holding
    nvm_read(8'h5A, 8'hA5);
    wr(OFS_NVM_ADDR, 8'h00);
    rd_chk(OFS_NVM_DATA, 8'hA5);
    // array boundaries
    nvm_write(8'hFF, 8'h3C);
    nvm_write(8'h00, 8'hC3);
    nvm_read(8'hFF, 8'h3C);
    nvm_read(8'h00, 8'hC3);
    nvm_read(8'h5A, 8'hA5);
    end_sim();
  end

endmodule
